// ==== bench/proc_model.sv ====
// Processor side of the register port: issues one request per cycle.
// Assumes callers go back to back or call idle before stopping.
`timescale 1ns/1ns
`default_nettype none
module proc_model (
  // Clock
  input wire logic mclk,
  // Register port
  output var usb_led_regs_pkg::reg_req_t req
);
  import usb_led_regs_pkg::*;
  initial req = '0;
  task automatic access(input logic r, input logic w, input logic [ADDR_W-1:0] a,
                        input logic [DATA_W-1:0] d);
    @(negedge mclk);
    req = '{addr: a, wr: w, rd: r, wdata: d};
  endtask
  // Released lines show the inverse so stale values never pass
  task automatic idle();
    @(negedge mclk);
    req = '{addr: ~req.addr, wr: 1'b0, rd: 1'b0, wdata: ~req.wdata};
  endtask
endmodule
`default_nettype wire

// ==== bench/testbench.sv ====
// Self-checking bench for the USB supply and backlight register bank.
// Assumes proc_model drives the port and a shadow model predicts reads.
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import usb_led_regs_pkg::*;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic main_reset_n = 1'b1;
  logic power_up_strap = 1'b1;
  logic vbus_invalid = 1'b0;
  logic mr = 1'b0;
  reg_req_t req;
  logic [DATA_W-1:0] reg_rdata_r;
  logic reg_ack_r;
  logic [DATA_W-1:0] sh [3];
  logic [DATA_W-1:0] msk [3] = '{24'h400040, 24'h060509, 24'h007FFF};
  logic [DATA_W:0] exp_q [$];
  logic [DATA_W:0] e;
  int n_mismatch = 0;
  int checks_done = 0;
  int seed = 60;
  always #5 mclk = ~mclk;
  proc_model pm (.mclk(mclk), .req(req));
  usb_backlight_ctrl dut (.mclk(mclk), .rst(rst), .req(req), .reg_rdata_r(reg_rdata_r),
    .reg_ack_r(reg_ack_r), .main_reset_n(main_reset_n), .power_up_strap(power_up_strap),
    .vbus_invalid(vbus_invalid), .usb_id_r(), .usb_supply_r(), .backlight_r(),
    .strap_open_r());
  // --------
  // Shadow model and access tasks
  // --------
  function automatic logic [DATA_W-1:0] get(input logic [ADDR_W-1:0] a);
    return (a >= 6'h31 && a <= 6'h33) ? sh[a-6'h31] : RDATA_ZERO;
  endfunction
  task automatic put(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    if (!mr && a >= 6'h31 && a <= 6'h33) sh[a-6'h31] = (sh[a-6'h31] & ~msk[a-6'h31]) | (d & msk[a-6'h31]);
    if (vbus_invalid && power_up_strap) sh[1][3] = 1'b1;
  endtask
  // A combined read and write returns the word from before the write
  task automatic acc(input logic r, input logic w, input logic [ADDR_W-1:0] a,
                     input logic [DATA_W-1:0] d);
    exp_q.push_back({r, get(a)});
    pm.access(r, w, a, d);
    if (w) put(a, d);
  endtask
  task automatic rdall();
    for (int a = 'h30; a <= 'h34; a++) begin
      acc(1'b1, 1'b0, 6'(a), 24'h0);
    end
    pm.idle();
  endtask
  task automatic por();
    sh = '{24'h000040, 24'h000008, 24'h000000};
  endtask
  task automatic mreset();
    pm.idle();
    main_reset_n = 1'b0;
    repeat (8) @(negedge mclk);
    sh[0] = 24'h000040;
    sh[1] = (sh[1] & 24'h000001) | (power_up_strap ? 24'h000008 : sh[1] & 24'h000008);
    sh[2] = 24'h000000;
    mr = 1'b1;
    acc(1'b0, 1'b1, 6'h33, 24'hFFFFFF);
    acc(1'b1, 1'b0, 6'h33, 24'h000000);
    pm.idle();
    main_reset_n = 1'b1;
    mr = 1'b0;
    repeat (8) @(negedge mclk);
  endtask
  task automatic pins(input logic s, input logic v);
    pm.idle();
    power_up_strap = s;
    vbus_invalid = v;
    repeat (10) @(negedge mclk);
    if (v && s) sh[1][3] = 1'b1;
  endtask
  task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("Checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // --------
  // Result monitor
  // --------
  // Sampled mid-cycle, where ack and read data have settled
  always @(negedge mclk) begin
    if (reg_ack_r === 1'b1) begin
      if (exp_q.size() == 0) begin
        chk(24'h000001, 24'h000000);
      end else begin
        e = exp_q.pop_front();
        if (e[DATA_W]) chk(reg_rdata_r, e[DATA_W-1:0]);
      end
    end
  end
  // --------
  // Main sequence
  // --------
  initial begin
    por();
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    rst = 1'b0;
    rdall();
    repeat (60) begin
      acc(1'($random(seed)), 1'b1, 6'h30 + 6'($unsigned($random(seed)) % 5), 24'($random(seed)));
    end
    rdall();
    for (int a = 'h31; a <= 'h33; a++) begin
      acc(1'b0, 1'b1, 6'(a), 24'hFFFFFF);
    end
    mreset();
    rdall();
    // Strap grounded: main reset and invalid VBUS both leave the enable alone
    pins(1'b0, 1'b0);
    acc(1'b0, 1'b1, 6'h32, 24'h000001);
    mreset();
    rdall();
    pins(1'b0, 1'b1);
    rdall();
    pins(1'b1, 1'b0);
    mreset();
    acc(1'b0, 1'b1, 6'h32, 24'h000000);
    pins(1'b1, 1'b1);
    acc(1'b0, 1'b1, 6'h32, 24'h000000);
    rdall();
    pins(1'b1, 1'b0);
    rst = 1'b1;
    repeat (2) @(negedge mclk);
    rst = 1'b0;
    por();
    rdall();
    repeat (4) @(negedge mclk);
    chk(24'(exp_q.size()), 24'h000000);
    stop_test();
  end
  initial begin
    #100000;
    n_mismatch++;
    stop_test();
  end
endmodule
`default_nettype wire

// ==== bench/usb_backlight_ctrl_properties.sv ====
// Assertion checker for the USB supply and backlight register bank.
// Assumes it is bound to usb_backlight_ctrl and sees its ports only.
`timescale 1ns/1ns
`default_nettype none
module usb_backlight_checker (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Register port
  input wire usb_led_regs_pkg::reg_req_t req,
  input wire logic [usb_led_regs_pkg::DATA_W-1:0] reg_rdata_r,
  input wire logic reg_ack_r,
  // Pins
  input wire logic main_reset_n,
  input wire logic power_up_strap,
  input wire logic vbus_invalid,
  // Fields
  input wire usb_led_regs_pkg::usb_id_t usb_id_r,
  input wire usb_led_regs_pkg::usb_supply_t usb_supply_r,
  input wire usb_led_regs_pkg::backlight_t backlight_r,
  input wire logic strap_open_r
);
  import usb_led_regs_pkg::*;
  // --------
  // Main reset pin high-time counter
  // --------
  // Saturates at 8: by then the pin pipeline has let go of the fields
  logic [3:0] hi_cnt_r;
  logic [3:0] hi_cnt_nxt;
  logic wr32;
  always_comb begin
    hi_cnt_nxt = hi_cnt_r;
    if (!main_reset_n) begin
      hi_cnt_nxt = 4'h0;
    end else if (hi_cnt_r != 4'h8) begin
      hi_cnt_nxt = hi_cnt_r + 4'h1;
    end
  end
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      hi_cnt_r <= 4'h8;
    end else begin
      hi_cnt_r <= hi_cnt_nxt;
    end
  end
  assign wr32 = req.wr && req.addr == USB_SUPPLY_CONTROL_ADDR;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  // --------
  // Properties
  // --------
  property p_ack;
    req.rd || req.wr |=> reg_ack_r;
  endproperty
  a_ack: assert property (p_ack) else $error("no ack after request");
  property p_unmapped;
    req.rd && !(req.addr inside {6'h31, 6'h32, 6'h33}) |=> reg_rdata_r == RDATA_ZERO;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_rsv_id;
    req.rd && req.addr == USB_ID_CONTROL_ADDR |=> (reg_rdata_r & 24'hBFFFBF) == 24'h000000;
  endproperty
  a_rsv_id: assert property (p_rsv_id) else $error("reserved id bits set");
  property p_rsv_sup;
    req.rd && req.addr == USB_SUPPLY_CONTROL_ADDR |=> (reg_rdata_r & 24'hF9FAF6) == 24'h000000;
  endproperty
  a_rsv_sup: assert property (p_rsv_sup) else $error("reserved supply bits set");
  property p_rsv_bl;
    req.rd && req.addr == DISPLAY_BACKLIGHT_CONTROL_ADDR |=> reg_rdata_r[23:15] == 9'h000;
  endproperty
  a_rsv_bl: assert property (p_rsv_bl) else $error("unused backlight bits set");
  property p_dir_keep;
    !wr32 |=> $stable(usb_supply_r.bus_power_direction);
  endproperty
  a_dir_keep: assert property (p_dir_keep) else $error("bus direction moved");
  property p_main_clr;
    !main_reset_n [*7] |-> usb_id_r == 2'b01 && backlight_r == 15'h0000
      && usb_supply_r[5:2] == 4'h0 && (usb_supply_r.usb_supply_enable || !strap_open_r);
  endproperty
  a_main_clr: assert property (p_main_clr) else $error("main reset values wrong");
  property p_vbus_set;
    vbus_invalid [*7] ##0 strap_open_r |-> usb_supply_r.usb_supply_enable;
  endproperty
  a_vbus_set: assert property (p_vbus_set) else $error("invalid vbus left supply off");
  property p_gnd_keep;
    !strap_open_r && !wr32 ##1 !strap_open_r |-> $stable(usb_supply_r.usb_supply_enable);
  endproperty
  a_gnd_keep: assert property (p_gnd_keep) else $error("grounded strap enable moved");
  property p_write_bl;
    req.wr && req.addr == DISPLAY_BACKLIGHT_CONTROL_ADDR && hi_cnt_r == 4'h8
      |=> backlight_r == $past(req.wdata[14:0]);
  endproperty
  a_write_bl: assert property (p_write_bl) else $error("backlight write lost");
endmodule
bind usb_backlight_ctrl usb_backlight_checker u_chk (.mclk(mclk), .rst(rst), .req(req),
  .reg_rdata_r(reg_rdata_r), .reg_ack_r(reg_ack_r), .main_reset_n(main_reset_n),
  .power_up_strap(power_up_strap), .vbus_invalid(vbus_invalid), .usb_id_r(usb_id_r),
  .usb_supply_r(usb_supply_r), .backlight_r(backlight_r), .strap_open_r(strap_open_r));
`default_nettype wire

// ==== logic/pin_sync.sv ====
// Three-stage synchroniser with agreement filter for asynchronous pins.
// Assumes the pins are slow levels; short glitches are dropped.
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Levels
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] pin_out
);
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : gen_bit
      logic s1_r, s2_r, s3_r, out_r, out_nxt;
      // Stage one feeds only stage two, never the filter
      always_comb begin
        out_nxt = (s2_r == s3_r) ? s2_r : out_r;
      end
      always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
          s1_r <= RST_VAL[g];
          s2_r <= RST_VAL[g];
          s3_r <= RST_VAL[g];
          out_r <= RST_VAL[g];
        end else begin
          s1_r <= pin_in[g];
          s2_r <= s1_r;
          s3_r <= s2_r;
          out_r <= out_nxt;
        end
      end
      assign pin_out[g] = out_r;
    end
  endgenerate
endmodule
`default_nettype wire

// ==== logic/reg_readback.sv ====
// Assembles the read word of the addressed register from the field structs.
// Assumes unmapped addresses answer with zero.
`timescale 1ns/1ns
`default_nettype none
module reg_readback (
  // Address
  input wire logic [usb_led_regs_pkg::ADDR_W-1:0] addr,
  // Field state
  input wire usb_led_regs_pkg::usb_id_t usb_id,
  input wire usb_led_regs_pkg::usb_supply_t usb_supply,
  input wire usb_led_regs_pkg::backlight_t backlight,
  // Word
  output logic [usb_led_regs_pkg::DATA_W-1:0] rword
);
  import usb_led_regs_pkg::*;

  always_comb begin
    rword = RDATA_ZERO;
    case (addr)
      USB_ID_CONTROL_ADDR: begin
        rword[ID_SPARE6_POS] = usb_id.spare6;
        rword[ID_PULLUP_SOURCE_SEL_POS] = usb_id.id_pullup_source_sel;
      end
      USB_SUPPLY_CONTROL_ADDR: begin
        rword[BUS_POWER_DIRECTION_POS] = usb_supply.bus_power_direction;
        rword[USB_SUPPLY_ENABLE_POS] = usb_supply.usb_supply_enable;
        rword[ID_WEAK_PULLUP_ENABLE_POS] = usb_supply.id_weak_pullup_enable;
        rword[OTG_BOOST_ENABLE_POS] = usb_supply.otg_boost_enable;
        rword[SUPPLY_SPARE17_POS] = usb_supply.spare17;
        rword[SUPPLY_SPARE18_POS] = usb_supply.spare18;
      end
      DISPLAY_BACKLIGHT_CONTROL_ADDR: begin
        rword[BL_SPARE0_POS] = backlight.spare0;
        rword[MAIN_BACKLIGHT_HIGH_CURRENT_POS] = backlight.main_backlight_high_current;
        rword[MAIN_BACKLIGHT_RAMP_ENABLE_POS] = backlight.main_backlight_ramp_enable;
        rword[MAIN_BACKLIGHT_DUTY_LSB +: MAIN_BACKLIGHT_DUTY_W] =
          backlight.main_backlight_duty;
        rword[MAIN_BACKLIGHT_CURRENT_LSB +: MAIN_BACKLIGHT_CURRENT_W] =
          backlight.main_backlight_current;
        rword[BL_SPARE12_POS] = backlight.spare12;
        rword[AUX_BACKLIGHT_HIGH_CURRENT_POS] = backlight.aux_backlight_high_current;
        rword[AUX_BACKLIGHT_RAMP_ENABLE_POS] = backlight.aux_backlight_ramp_enable;
      end
      default: begin
        rword = RDATA_ZERO;
      end
    endcase
  end
endmodule
`default_nettype wire

// ==== logic/usb_backlight_ctrl.sv ====
// USB supply/ID and display backlight control register bank.
// Assumes a word-wide register port from the serial control front end on mclk,
// and main reset, strap and VBUS-invalid as asynchronous pin levels.
//
// How it works
// - usb_id_control bit 22 selects ID pull-up source; main reset clears it.
// - usb_supply_control bit 0 sets bus power direction; main reset keeps it.
// - Bit 3 supply enable: with strap open, main reset or invalid VBUS sets it.
// - Bit 8 switches in the weak ID pull-up; main reset clears it.
// - Bit 10 enables boost for on-the-go; main reset clears it.
// - display_backlight_control bit 1 main high-current mode; cleared by reset.
// - Bit 2 main backlight ramp enable; cleared by main reset.
// - Bits 3 to 8 main backlight duty; cleared by main reset.
// - Bits 9 to 11 main backlight current; cleared by main reset.
// - Bit 13 auxiliary high-current mode; cleared by main reset.
// - Bit 14 auxiliary ramp enable; cleared by main reset.
`timescale 1ns/1ns
`default_nettype none
module usb_backlight_ctrl (
  // Clock and power-on reset
  input wire logic mclk,
  input wire logic rst,
  // Register port
  input wire usb_led_regs_pkg::reg_req_t req,
  output logic [usb_led_regs_pkg::DATA_W-1:0] reg_rdata_r,
  output logic reg_ack_r,
  // Pins: main reset, power-up strap, VBUS invalid
  input wire logic main_reset_n,
  input wire logic power_up_strap,
  input wire logic vbus_invalid,
  // Field outputs
  output usb_led_regs_pkg::usb_id_t usb_id_r,
  output usb_led_regs_pkg::usb_supply_t usb_supply_r,
  output usb_led_regs_pkg::backlight_t backlight_r,
  output logic strap_open_r
);
  import usb_led_regs_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisation
  // ----------------------------------------------------------------
  logic [PIN_W-1:0] pins_raw;
  logic [PIN_W-1:0] pins_sync;
  logic main_rst_active;
  logic vbus_bad;

  assign pins_raw = {main_reset_n, power_up_strap, vbus_invalid};

  pin_sync #(
    .WIDTH(PIN_W),
    .RST_VAL(PIN_RST_VAL)
  ) u_pin_sync (
    .mclk(mclk),
    .rst(rst),
    .pin_in(pins_raw),
    .pin_out(pins_sync)
  );

  assign main_rst_active = ~pins_sync[PIN_MAIN_RESET_N];
  assign vbus_bad = pins_sync[PIN_VBUS_INVALID];

  // ----------------------------------------------------------------
  // Strap capture
  // ----------------------------------------------------------------
  // Strap is taken while main reset is held and once after power-on,
  // so a strap that moves during operation cannot change VBUS behaviour until the next main reset.
  logic strap_valid_r, strap_valid_nxt;
  logic strap_open_nxt;

  always_comb begin
    strap_valid_nxt = 1'b1;
    strap_open_nxt = strap_open_r;
    if (!strap_valid_r || main_rst_active) begin
      strap_open_nxt = pins_sync[PIN_STRAP];
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      strap_valid_r <= 1'b0;
      strap_open_r <= 1'b1;
    end else begin
      strap_valid_r <= strap_valid_nxt;
      strap_open_r <= strap_open_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Write decode
  // ----------------------------------------------------------------
  // Writes are ignored while the main reset is held.
  logic wr_id, wr_supply, wr_bl;

  always_comb begin
    wr_id = req.wr && !main_rst_active && (req.addr == USB_ID_CONTROL_ADDR);
    wr_supply = req.wr && !main_rst_active && (req.addr == USB_SUPPLY_CONTROL_ADDR);
    wr_bl = req.wr && !main_rst_active && (req.addr == DISPLAY_BACKLIGHT_CONTROL_ADDR);
  end

  // ----------------------------------------------------------------
  // usb_id_control
  // ----------------------------------------------------------------
  usb_id_t usb_id_nxt;

  always_comb begin
    usb_id_nxt = usb_id_r;
    if (main_rst_active) begin
      usb_id_nxt.id_pullup_source_sel = RST_ID_PULLUP_SOURCE_SEL;
      usb_id_nxt.spare6 = RST_ID_SPARE6;
    end else if (wr_id) begin
      usb_id_nxt.id_pullup_source_sel = req.wdata[ID_PULLUP_SOURCE_SEL_POS];
      usb_id_nxt.spare6 = req.wdata[ID_SPARE6_POS];
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      usb_id_r.id_pullup_source_sel <= RST_ID_PULLUP_SOURCE_SEL;
      usb_id_r.spare6 <= RST_ID_SPARE6;
    end else begin
      usb_id_r <= usb_id_nxt;
    end
  end

  // ----------------------------------------------------------------
  // usb_supply_control
  // ----------------------------------------------------------------
  usb_supply_t usb_supply_nxt;

  always_comb begin
    usb_supply_nxt = usb_supply_r;
    if (main_rst_active) begin
      // Direction survives the main reset; of the two resets only power-on loads it
      usb_supply_nxt.bus_power_direction = usb_supply_r.bus_power_direction;
      if (strap_open_nxt) begin
        usb_supply_nxt.usb_supply_enable = RST_USB_SUPPLY_ENABLE;
      end
      usb_supply_nxt.id_weak_pullup_enable = RST_ID_WEAK_PULLUP_ENABLE;
      usb_supply_nxt.otg_boost_enable = RST_OTG_BOOST_ENABLE;
      usb_supply_nxt.spare17 = RST_SUPPLY_SPARE;
      usb_supply_nxt.spare18 = RST_SUPPLY_SPARE;
    end else if (wr_supply) begin
      usb_supply_nxt.bus_power_direction = req.wdata[BUS_POWER_DIRECTION_POS];
      usb_supply_nxt.usb_supply_enable = req.wdata[USB_SUPPLY_ENABLE_POS];
      usb_supply_nxt.id_weak_pullup_enable = req.wdata[ID_WEAK_PULLUP_ENABLE_POS];
      usb_supply_nxt.otg_boost_enable = req.wdata[OTG_BOOST_ENABLE_POS];
      usb_supply_nxt.spare17 = req.wdata[SUPPLY_SPARE17_POS];
      usb_supply_nxt.spare18 = req.wdata[SUPPLY_SPARE18_POS];
    end
    // Invalid VBUS outranks a same-cycle write that clears the enable
    if (vbus_bad && strap_open_r) begin
      usb_supply_nxt.usb_supply_enable = RST_USB_SUPPLY_ENABLE;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      usb_supply_r.bus_power_direction <= POR_BUS_POWER_DIRECTION;
      usb_supply_r.usb_supply_enable <= POR_USB_SUPPLY_ENABLE;
      usb_supply_r.id_weak_pullup_enable <= RST_ID_WEAK_PULLUP_ENABLE;
      usb_supply_r.otg_boost_enable <= RST_OTG_BOOST_ENABLE;
      usb_supply_r.spare17 <= RST_SUPPLY_SPARE;
      usb_supply_r.spare18 <= RST_SUPPLY_SPARE;
    end else begin
      usb_supply_r <= usb_supply_nxt;
    end
  end

  // ----------------------------------------------------------------
  // display_backlight_control
  // ----------------------------------------------------------------
  // Auxiliary duty and current bits are not held here and read as zero.
  backlight_t backlight_nxt;

  always_comb begin
    backlight_nxt = backlight_r;
    if (main_rst_active) begin
      backlight_nxt.spare0 = RST_BL_BIT;
      backlight_nxt.main_backlight_high_current = RST_BL_BIT;
      backlight_nxt.main_backlight_ramp_enable = RST_BL_BIT;
      backlight_nxt.main_backlight_duty = RST_MAIN_BACKLIGHT_DUTY;
      backlight_nxt.main_backlight_current = RST_MAIN_BACKLIGHT_CURRENT;
      backlight_nxt.spare12 = RST_BL_BIT;
      backlight_nxt.aux_backlight_high_current = RST_BL_BIT;
      backlight_nxt.aux_backlight_ramp_enable = RST_BL_BIT;
    end else if (wr_bl) begin
      backlight_nxt.spare0 = req.wdata[BL_SPARE0_POS];
      backlight_nxt.main_backlight_high_current =
        req.wdata[MAIN_BACKLIGHT_HIGH_CURRENT_POS];
      backlight_nxt.main_backlight_ramp_enable =
        req.wdata[MAIN_BACKLIGHT_RAMP_ENABLE_POS];
      backlight_nxt.main_backlight_duty =
        req.wdata[MAIN_BACKLIGHT_DUTY_LSB +: MAIN_BACKLIGHT_DUTY_W];
      backlight_nxt.main_backlight_current =
        req.wdata[MAIN_BACKLIGHT_CURRENT_LSB +: MAIN_BACKLIGHT_CURRENT_W];
      backlight_nxt.spare12 = req.wdata[BL_SPARE12_POS];
      backlight_nxt.aux_backlight_high_current =
        req.wdata[AUX_BACKLIGHT_HIGH_CURRENT_POS];
      backlight_nxt.aux_backlight_ramp_enable =
        req.wdata[AUX_BACKLIGHT_RAMP_ENABLE_POS];
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      backlight_r.spare0 <= RST_BL_BIT;
      backlight_r.main_backlight_high_current <= RST_BL_BIT;
      backlight_r.main_backlight_ramp_enable <= RST_BL_BIT;
      backlight_r.main_backlight_duty <= RST_MAIN_BACKLIGHT_DUTY;
      backlight_r.main_backlight_current <= RST_MAIN_BACKLIGHT_CURRENT;
      backlight_r.spare12 <= RST_BL_BIT;
      backlight_r.aux_backlight_high_current <= RST_BL_BIT;
      backlight_r.aux_backlight_ramp_enable <= RST_BL_BIT;
    end else begin
      backlight_r <= backlight_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Read data and acknowledge
  // ----------------------------------------------------------------
  // Read shows the state before any same-cycle write.
  logic [DATA_W-1:0] rword;
  logic [DATA_W-1:0] reg_rdata_nxt;
  logic reg_ack_nxt;

  reg_readback u_reg_readback (
    .addr(req.addr),
    .usb_id(usb_id_r),
    .usb_supply(usb_supply_r),
    .backlight(backlight_r),
    .rword(rword)
  );

  always_comb begin
    reg_rdata_nxt = reg_rdata_r;
    if (req.rd) begin
      reg_rdata_nxt = rword;
    end
    reg_ack_nxt = req.rd || req.wr;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      reg_rdata_r <= RDATA_ZERO;
      reg_ack_r <= 1'b0;
    end else begin
      reg_rdata_r <= reg_rdata_nxt;
      reg_ack_r <= reg_ack_nxt;
    end
  end

endmodule
`default_nettype wire

// ==== logic/usb_led_regs_pkg.sv ====
// Constants and types for the USB and display backlight control bank.
// Assumes a 6-bit register address and 24-bit register data.
package usb_led_regs_pkg;

  // ----------------------------------------------------------------
  // Register port geometry and offsets
  // ----------------------------------------------------------------
  localparam int ADDR_W = 6;
  localparam int DATA_W = 24;
  localparam logic [ADDR_W-1:0] USB_ID_CONTROL_ADDR = 6'h31;
  localparam logic [ADDR_W-1:0] USB_SUPPLY_CONTROL_ADDR = 6'h32;
  localparam logic [ADDR_W-1:0] DISPLAY_BACKLIGHT_CONTROL_ADDR = 6'h33;

  // ----------------------------------------------------------------
  // Field positions: usb_id_control
  // ----------------------------------------------------------------
  localparam int ID_SPARE6_POS = 6;
  localparam int ID_PULLUP_SOURCE_SEL_POS = 22;

  // ----------------------------------------------------------------
  // Field positions: usb_supply_control
  // ----------------------------------------------------------------
  localparam int BUS_POWER_DIRECTION_POS = 0;
  localparam int USB_SUPPLY_ENABLE_POS = 3;
  localparam int ID_WEAK_PULLUP_ENABLE_POS = 8;
  localparam int OTG_BOOST_ENABLE_POS = 10;
  localparam int SUPPLY_SPARE17_POS = 17;
  localparam int SUPPLY_SPARE18_POS = 18;

  // ----------------------------------------------------------------
  // Field positions: display_backlight_control
  // ----------------------------------------------------------------
  localparam int BL_SPARE0_POS = 0;
  localparam int MAIN_BACKLIGHT_HIGH_CURRENT_POS = 1;
  localparam int MAIN_BACKLIGHT_RAMP_ENABLE_POS = 2;
  localparam int MAIN_BACKLIGHT_DUTY_LSB = 3;
  localparam int MAIN_BACKLIGHT_DUTY_W = 6;
  localparam int MAIN_BACKLIGHT_CURRENT_LSB = 9;
  localparam int MAIN_BACKLIGHT_CURRENT_W = 3;
  localparam int BL_SPARE12_POS = 12;
  localparam int AUX_BACKLIGHT_HIGH_CURRENT_POS = 13;
  localparam int AUX_BACKLIGHT_RAMP_ENABLE_POS = 14;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic RST_ID_SPARE6 = 1'b1;
  localparam logic RST_ID_PULLUP_SOURCE_SEL = 1'b0;
  // Power-on values of the fields the main reset leaves alone: direction always, enable with strap grounded
  localparam logic POR_BUS_POWER_DIRECTION = 1'b0;
  localparam logic POR_USB_SUPPLY_ENABLE = 1'b1;
  localparam logic RST_USB_SUPPLY_ENABLE = 1'b1;
  localparam logic RST_ID_WEAK_PULLUP_ENABLE = 1'b0;
  localparam logic RST_OTG_BOOST_ENABLE = 1'b0;
  localparam logic RST_SUPPLY_SPARE = 1'b0;
  localparam logic RST_BL_BIT = 1'b0;
  localparam logic [MAIN_BACKLIGHT_DUTY_W-1:0] RST_MAIN_BACKLIGHT_DUTY = 6'h00;
  localparam logic [MAIN_BACKLIGHT_CURRENT_W-1:0] RST_MAIN_BACKLIGHT_CURRENT = 3'h0;
  localparam logic [DATA_W-1:0] RDATA_ZERO = 24'h000000;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic id_pullup_source_sel;
    logic spare6;
  } usb_id_t;

  typedef struct packed {
    logic spare18;
    logic spare17;
    logic otg_boost_enable;
    logic id_weak_pullup_enable;
    logic usb_supply_enable;
    logic bus_power_direction;
  } usb_supply_t;

  typedef struct packed {
    logic aux_backlight_ramp_enable;
    logic aux_backlight_high_current;
    logic spare12;
    logic [MAIN_BACKLIGHT_CURRENT_W-1:0] main_backlight_current;
    logic [MAIN_BACKLIGHT_DUTY_W-1:0] main_backlight_duty;
    logic main_backlight_ramp_enable;
    logic main_backlight_high_current;
    logic spare0;
  } backlight_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic wr;
    logic rd;
    logic [DATA_W-1:0] wdata;
  } reg_req_t;

  // Pin levels: main_reset_n, power_up_strap, vbus_invalid
  localparam int PIN_W = 3;
  localparam int PIN_MAIN_RESET_N = 2;
  localparam int PIN_STRAP = 1;
  localparam int PIN_VBUS_INVALID = 0;
  // Main reset idle, strap open, VBUS valid
  localparam logic [PIN_W-1:0] PIN_RST_VAL = 3'h6;

endpackage
